// >>> core/pmrs_map.svh
// constants for the power-mode and reset sequencer
`ifndef PMRS_MAP_SVH
`define PMRS_MAP_SVH
`define PMRS_CLK_HZ         20000000
`define PMRS_IRC_HZ         4000000
`define PMRS_IRC_WAKE_CYC   4
`define PMRS_OSC_WAKE_CYC   4096
`define PMRS_IRC_START_US   60
`define PMRS_FLASH_START_US 100
`define PMRS_RST_HOLD_CYC   16
`define PMRS_BOOT_VECTOR    32'h0000_0000
`define PMRS_LVL_NONE       2'h0
`define PMRS_LVL_ONE        2'h1
`define PMRS_LVL_TWO        2'h2
`define PMRS_LVL_THREE      2'h3
`endif

// >>> core/pmrs_pkg.sv
// types for the power-mode and reset sequencer
package pmrs_pkg;
   typedef enum logic [1:0] {
      PMRS_REQ_IDLE  = 2'h0,
      PMRS_REQ_SLEEP = 2'h1,
      PMRS_REQ_PDOWN = 2'h2,
      PMRS_REQ_DEEP  = 2'h3
   } pmrs_req_t;
   typedef enum logic [5:0] {
      PMRS_ST_RESET = 6'h01,
      PMRS_ST_RUN   = 6'h02,
      PMRS_ST_IDLE  = 6'h04,
      PMRS_ST_SLEEP = 6'h08,
      PMRS_ST_PDOWN = 6'h10,
      PMRS_ST_WAKE  = 6'h20
   } pmrs_state_t;
   typedef struct packed {
      logic ext_reset;
      logic watchdog;
      logic power_on;
      logic brownout_low;
   } pmrs_rst_src_t;
   typedef struct packed {
      logic jtag_enable;
      logic loader_enable;
      logic loader_sector0;
      logic loader_partial;
      logic loader_force_enable;
      logic app_flash_calls;
   } pmrs_access_t;
endpackage

// >>> core/pmrs_sequencer.sv
// power-mode and reset sequencer
`timescale 1ns/1ps
`include "pmrs_map.svh"
// Summary of operation
// - sleep stops oscillator, gates clocks, keeps state
// - sleep blocks rc output, rc stays powered
// - rtc oscillator keeps running during sleep
// - sleep entry powers off and bypasses pll
// - sleep entry clears core and usb dividers
// - leave sleep only on reset or clockless irq
// - flash stays powered throughout sleep
// - rc wake from sleep resumes after 4 cycles
// - oscillator wake from sleep waits 4096 cycles
// - power-down also stops rc oscillator and flash
// - power-down rc wake waits 60 us rc start-up
// - then 4 rc cycles before sram execution
// - flash timer permits flash after 100 us
// - deep power-down exits through full chip reset
// - deep power-down wakes on rtc alarm or reset
// - four reset sources merge into chip reset
// - reset held until pin, oscillator, count, flash ready
// - after reset fetch begins at address zero
// - first brownout raises irq and status bit
// - second brownout holds reset until power-on
// - levels one, two block jtag, limit loader
// - level three blocks jtag and all loader access
module pmrs_sequencer #(
   parameter int WAKE_OSC_CYC = `PMRS_OSC_WAKE_CYC,
   parameter int RST_HOLD_CYC = `PMRS_RST_HOLD_CYC
) (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire pmrs_pkg::pmrs_rst_src_t rst_src,
   input  wire logic                  osc_running,
   input  wire logic                  flash_init_done,
   input  wire logic                  brownout_warn,
   input  wire pmrs_pkg::pmrs_req_t   power_req,
   input  wire logic                  wait_for_irq,
   input  wire logic                  clockless_irq,
   input  wire logic                  any_irq,
   input  wire logic                  rtc_alarm,
   input  wire logic                  clk_src_main_osc,
   input  wire logic [1:0]            protect_level,
   output logic                       chip_reset,
   output logic [31:0]                fetch_addr,
   output logic                       core_clk_enable,
   output logic                       periph_clk_enable,
   output logic                       internal_rc_oscillator_power,
   output logic                       internal_rc_oscillator_out_en,
   output logic                       main_osc_enable,
   output logic                       rtc_osc_enable,
   output logic                       pll_power,
   output logic                       pll_connect,
   output logic                       divider_clear,
   output logic                       flash_power,
   output logic                       flash_access_ok,
   output logic                       regulator_enable,
   output logic                       brownout_detector_irq,
   output logic                       brownout_detector_status,
   output pmrs_pkg::pmrs_access_t     access
);
   localparam int IRC_DIV      = `PMRS_CLK_HZ / `PMRS_IRC_HZ;
   localparam int IRC_WAKE_CLK = `PMRS_IRC_WAKE_CYC * IRC_DIV;
   localparam int RC_START_CLK = (`PMRS_IRC_START_US * (`PMRS_CLK_HZ / 1000000));
   localparam int FLASH_CLK    = (`PMRS_FLASH_START_US * (`PMRS_CLK_HZ / 1000000));

   // counters are sixteen bits wide, so larger counts cannot be served
   if (WAKE_OSC_CYC < 1 || WAKE_OSC_CYC > 65535 || RST_HOLD_CYC < 1
       || RST_HOLD_CYC > 65535) begin : g_bad_counts
      $error("pmrs_sequencer: counts out of range");
   end

   pmrs_pkg::pmrs_state_t state_q, state_d;
   logic [15:0] cnt_q, cnt_d;
   logic [15:0] fcnt_q, fcnt_d;
   logic        pdown_q, pdown_d;
   logic        flash_ok_q, flash_ok_d;
   logic        deep_q, deep_d;
   logic        bo_q, bo_d;
   logic        src_any;

   // the synchronous reset or any of the four reset sources restarts the chip
   assign src_any = rst | rst_src.ext_reset | rst_src.watchdog | rst_src.power_on
                    | rst_src.brownout_low;

   function automatic logic [15:0] c16(input int v);
      c16 = 16'(v);
   endfunction

   always_comb begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      fcnt_d     = fcnt_q;
      pdown_d    = pdown_q;
      flash_ok_d = flash_ok_q;
      deep_d     = deep_q;
      bo_d       = brownout_warn;
      // flash timer runs beside the resume count, even after run resumes
      if (fcnt_q != 16'h0000) begin
         fcnt_d = fcnt_q - 16'h0001;
         if (fcnt_q == 16'h0001) begin
            flash_ok_d = 1'b1;
         end
      end
      if (src_any) begin
         state_d    = pmrs_pkg::PMRS_ST_RESET;
         cnt_d      = c16(RST_HOLD_CYC);
         fcnt_d     = 16'h0000;
         pdown_d    = 1'b0;
         flash_ok_d = 1'b0;
         deep_d     = 1'b0;
      end else begin
         case (state_q)
            pmrs_pkg::PMRS_ST_RESET: begin
               // all four release conditions at once; flash counts as ready at init
               if (cnt_q != 16'h0000) begin
                  cnt_d = cnt_q - 16'h0001;
               end else if (osc_running && flash_init_done) begin
                  state_d    = pmrs_pkg::PMRS_ST_RUN;
                  flash_ok_d = 1'b1;
               end
            end
            pmrs_pkg::PMRS_ST_RUN: begin
               if (wait_for_irq) begin
                  case (power_req)
                     pmrs_pkg::PMRS_REQ_IDLE:  state_d = pmrs_pkg::PMRS_ST_IDLE;
                     pmrs_pkg::PMRS_REQ_SLEEP: state_d = pmrs_pkg::PMRS_ST_SLEEP;
                     pmrs_pkg::PMRS_REQ_PDOWN: begin
                        state_d    = pmrs_pkg::PMRS_ST_PDOWN;
                        flash_ok_d = 1'b0;
                     end
                     pmrs_pkg::PMRS_REQ_DEEP: begin
                        state_d    = pmrs_pkg::PMRS_ST_PDOWN;
                        flash_ok_d = 1'b0;
                        deep_d     = 1'b1;
                     end
                     default: state_d = pmrs_pkg::PMRS_ST_IDLE;
                  endcase
                  pdown_d = (power_req == pmrs_pkg::PMRS_REQ_PDOWN)
                            || (power_req == pmrs_pkg::PMRS_REQ_DEEP);
               end
            end
            pmrs_pkg::PMRS_ST_IDLE: begin
               if (any_irq) begin
                  state_d = pmrs_pkg::PMRS_ST_RUN;
               end
            end
            pmrs_pkg::PMRS_ST_SLEEP, pmrs_pkg::PMRS_ST_PDOWN: begin
               // deep state has no logic left awake except the rtc alarm path and the reset sources
               if (deep_q) begin
                  if (rtc_alarm) begin
                     state_d = pmrs_pkg::PMRS_ST_RESET;
                     cnt_d   = c16(RST_HOLD_CYC);
                     deep_d  = 1'b0;
                  end
               end else if (clockless_irq) begin
                  state_d = pmrs_pkg::PMRS_ST_WAKE;
                  if (clk_src_main_osc) begin
                     cnt_d = c16(WAKE_OSC_CYC);
                  end else if (pdown_q) begin
                     cnt_d  = c16(RC_START_CLK + IRC_WAKE_CLK);
                     fcnt_d = c16(RC_START_CLK + FLASH_CLK);
                  end else begin
                     cnt_d = c16(IRC_WAKE_CLK);
                  end
               end
            end
            pmrs_pkg::PMRS_ST_WAKE: begin
               if (cnt_q > 16'h0001) begin
                  cnt_d = cnt_q - 16'h0001;
               end else begin
                  state_d = pmrs_pkg::PMRS_ST_RUN;
                  cnt_d   = 16'h0000;
                  if (clk_src_main_osc && pdown_q) begin
                     flash_ok_d = 1'b1;
                  end
                  pdown_d = 1'b0;
               end
            end
            default: state_d = pmrs_pkg::PMRS_ST_RESET;
         endcase
      end
   end

   // registers only; the next values are all formed above
   always_ff @(posedge clock) begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      fcnt_q     <= fcnt_d;
      pdown_q    <= pdown_d;
      flash_ok_q <= flash_ok_d;
      deep_q     <= deep_d;
      bo_q       <= bo_d;
   end

   logic asleep;
   assign asleep = (state_q == pmrs_pkg::PMRS_ST_SLEEP) || (state_q == pmrs_pkg::PMRS_ST_PDOWN);

   // clocks and supplies; the sequencer registers keep running on clock while asleep
   always_comb begin
      chip_reset                    = (state_q == pmrs_pkg::PMRS_ST_RESET);
      fetch_addr                    = `PMRS_BOOT_VECTOR;
      core_clk_enable               = (state_q == pmrs_pkg::PMRS_ST_RUN);
      periph_clk_enable             = !asleep && !chip_reset
                                      && (state_q != pmrs_pkg::PMRS_ST_WAKE);
      internal_rc_oscillator_power  = !(asleep && pdown_q);
      internal_rc_oscillator_out_en = !asleep;
      main_osc_enable               = !asleep;
      rtc_osc_enable                = 1'b1;
      pll_power                     = !asleep && !chip_reset;
      pll_connect                   = 1'b0;
      divider_clear                 = asleep || chip_reset;
      flash_power                   = !(asleep && pdown_q) && !deep_q;
      flash_access_ok               = flash_ok_q;
      regulator_enable              = !deep_q;
      brownout_detector_irq         = bo_q;
      brownout_detector_status      = bo_q;
      access.app_flash_calls        = 1'b1;
      access.jtag_enable            = (protect_level == `PMRS_LVL_NONE);
      access.loader_enable          = (protect_level != `PMRS_LVL_THREE);
      access.loader_sector0         = (protect_level == `PMRS_LVL_NONE);
      access.loader_partial         = (protect_level != `PMRS_LVL_TWO)
                                      && (protect_level != `PMRS_LVL_THREE);
      access.loader_force_enable    = (protect_level != `PMRS_LVL_THREE);
   end

   // checks on the one clock; the synchronous reset masks them
   property p_rst_hold;
      @(posedge clock) disable iff (rst)
      $rose(chip_reset) |-> chip_reset [*8];
   endproperty
   a_rst_hold: assert property (p_rst_hold)
      else $error("reset released too early");

   property p_src;
      @(posedge clock) disable iff (rst)
      rst_src.watchdog |=> chip_reset;
   endproperty
   a_src: assert property (p_src)
      else $error("watchdog did not reset");

   property p_sleep_gate;
      @(posedge clock) disable iff (rst)
      asleep |-> !core_clk_enable && !pll_power && divider_clear && rtc_osc_enable;
   endproperty
   a_sleep_gate: assert property (p_sleep_gate)
      else $error("sleep left a clock running");

   // four rc cycles are twenty system clocks at the nominal rc rate
   property p_irc_wake;
      @(posedge clock) disable iff (rst || src_any)
      (state_q == pmrs_pkg::PMRS_ST_SLEEP && !pdown_q && !deep_q && clockless_irq
       && !clk_src_main_osc)
      |=> !core_clk_enable [*8] ##1 !core_clk_enable [*8] ##1 !core_clk_enable [*4]
      ##1 core_clk_enable;
   endproperty
   a_irc_wake: assert property (p_irc_wake)
      else $error("rc wake timing wrong");

   property p_sleep_flash;
      @(posedge clock) disable iff (rst)
      (state_q == pmrs_pkg::PMRS_ST_SLEEP && !pdown_q) |-> flash_power;
   endproperty
   a_sleep_flash: assert property (p_sleep_flash)
      else $error("flash lost power in sleep");

   property p_pd_flash;
      @(posedge clock) disable iff (rst)
      (state_q == pmrs_pkg::PMRS_ST_PDOWN) |-> !flash_power && !internal_rc_oscillator_power;
   endproperty
   a_pd_flash: assert property (p_pd_flash)
      else $error("power-down left rc or flash on");

   property p_bo;
      @(posedge clock) disable iff (rst)
      brownout_warn |=> brownout_detector_irq && brownout_detector_status;
   endproperty
   a_bo: assert property (p_bo)
      else $error("brownout warning missed");

   property p_read_protect_level_three;
      @(posedge clock) disable iff (rst)
      protect_level == `PMRS_LVL_THREE |-> !access.jtag_enable && !access.loader_enable
         && !access.loader_force_enable && access.app_flash_calls;
   endproperty
   a_read_protect_level_three: assert property (p_read_protect_level_three)
      else $error("level three access leak");

   // deep state keeps nothing, so the alarm must take the full reset path
   property p_deep_wake;
      @(posedge clock) disable iff (rst)
      (deep_q && rtc_alarm) |=> chip_reset;
   endproperty
   a_deep_wake: assert property (p_deep_wake)
      else $error("rtc alarm did not restart the chip");

   c_sleep: cover property (@(posedge clock) state_q == pmrs_pkg::PMRS_ST_SLEEP);
   c_pdown_wake: cover property (@(posedge clock) $rose(flash_access_ok) && !chip_reset);
   c_deep: cover property (@(posedge clock) deep_q && rtc_alarm);
   c_idle_wake: cover property (@(posedge clock) state_q == pmrs_pkg::PMRS_ST_IDLE && any_irq);
endmodule // pmrs_sequencer

// >>> verif/pmrs_bench.sv
// self-checking bench for the power-mode and reset sequencer
`timescale 1ns/1ps
`include "pmrs_map.svh"
module pmrs_sequencer_bench;
   logic                    clock, rst, osc_running, flash_init_done, brownout_warn;
   logic                    wait_for_irq, clockless_irq, any_irq, rtc_alarm, clk_src_main_osc;
   logic [1:0]              protect_level;
   pmrs_pkg::pmrs_rst_src_t rst_src;
   pmrs_pkg::pmrs_req_t     power_req;
   logic                    chip_reset, core_clk_enable, periph_clk_enable, rc_pwr, rc_out;
   logic                    main_osc_enable, rtc_osc_enable, pll_power, pll_connect;
   logic                    divider_clear, flash_power, flash_access_ok, regulator_enable;
   logic                    bod_irq, bod_status;
   logic [31:0]             fetch_addr;
   pmrs_pkg::pmrs_access_t  access;
   int                      n_errors, tests_run, n, m;
   localparam int HOLD = 16;
   localparam int KHZ = `PMRS_CLK_HZ / 1000000;
   // system clocks per rc cycle at the nominal rc rate
   localparam int RC_DIV = `PMRS_CLK_HZ / `PMRS_IRC_HZ;
   // wake count shortened so the run stays short
   pmrs_sequencer #(.WAKE_OSC_CYC(8), .RST_HOLD_CYC(HOLD)) u_dut (
      .clock(clock), .rst(rst), .rst_src(rst_src), .osc_running(osc_running),
      .flash_init_done(flash_init_done), .brownout_warn(brownout_warn), .power_req(power_req),
      .wait_for_irq(wait_for_irq), .clockless_irq(clockless_irq), .any_irq(any_irq),
      .rtc_alarm(rtc_alarm), .clk_src_main_osc(clk_src_main_osc),
      .protect_level(protect_level), .chip_reset(chip_reset), .fetch_addr(fetch_addr),
      .core_clk_enable(core_clk_enable), .periph_clk_enable(periph_clk_enable),
      .internal_rc_oscillator_power(rc_pwr), .internal_rc_oscillator_out_en(rc_out),
      .main_osc_enable(main_osc_enable), .rtc_osc_enable(rtc_osc_enable),
      .pll_power(pll_power), .pll_connect(pll_connect), .divider_clear(divider_clear),
      .flash_power(flash_power), .flash_access_ok(flash_access_ok),
      .regulator_enable(regulator_enable), .brownout_detector_irq(bod_irq),
      .brownout_detector_status(bod_status), .access(access));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task print_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task tick(input int k);
      repeat (k) @(negedge clock);
   endtask
   function automatic logic probe(input int sel);
      case (sel)
         0: return chip_reset === 1'b0;
         1: return core_clk_enable === 1'b1;
         2: return flash_access_ok === 1'b1;
         default: return chip_reset === 1'b1;
      endcase
   endfunction
   // counts samples before the probe holds; a bound keeps a stuck sequencer from hanging the run
   task automatic count_to(input int sel, output int c);
      c = 0;
      while (!probe(sel)) begin
         c++;
         if (c > 5000) begin
            n_errors++;
            $display("BAD wait %0d timed out", sel);
            print_verdict();
         end
         @(negedge clock);
      end
   endtask
   task enter(input pmrs_pkg::pmrs_req_t r);
      power_req = r;
      wait_for_irq = 1'b1;
      tick(1);
      wait_for_irq = 1'b0;
      tick(2);
   endtask
   task wake(input logic rtc);
      if (rtc) rtc_alarm = 1'b1;
      else clockless_irq = 1'b1;
      tick(1);
      rtc_alarm = 1'b0;
      clockless_irq = 1'b0;
   endtask
   task reset_and_hold;
      tick(30);
      chk("held", 1, chip_reset);
      flash_init_done = 1'b1;
      count_to(0, n);
      chk("fetch", `PMRS_BOOT_VECTOR, fetch_addr);
   endtask
   task sources;
      for (int i = 0; i < 4; i++) begin
         rst_src = pmrs_pkg::pmrs_rst_src_t'(4'h1 << i);
         tick(20);
         chk("src", 1, chip_reset);
         rst_src = '0;
         count_to(0, n);
         chk("hold", 1, n >= HOLD);
      end
   endtask
   task sleep_wake(input logic main, input int exp);
      clk_src_main_osc = main;
      enter(pmrs_pkg::PMRS_REQ_SLEEP);
      chk("gate", 0, {core_clk_enable, periph_clk_enable, main_osc_enable});
      chk("rc", 2, {rc_pwr, rc_out});
      chk("rtc", 1, rtc_osc_enable);
      chk("pll", 0, {pll_power, pll_connect});
      chk("div", 1, divider_clear);
      chk("flash", 1, flash_power);
      any_irq = 1'b1;
      tick(1);
      any_irq = 1'b0;
      tick(3);
      chk("asleep", 0, core_clk_enable);
      wake(1'b0);
      count_to(1, n);
      chk("wake", exp, n);
   endtask
   task pdown_wake;
      clk_src_main_osc = 1'b0;
      enter(pmrs_pkg::PMRS_REQ_PDOWN);
      chk("pdoff", 0, {rc_pwr, flash_power, core_clk_enable});
      wake(1'b0);
      fork
         count_to(1, n);
         count_to(2, m);
      join
      chk("pdrun", `PMRS_IRC_START_US * KHZ + `PMRS_IRC_WAKE_CYC * RC_DIV, n);
      chk("pdflash", `PMRS_FLASH_START_US * KHZ + `PMRS_IRC_START_US * KHZ, m);
   endtask
   task deep_and_idle;
      enter(pmrs_pkg::PMRS_REQ_DEEP);
      chk("reg", 0, regulator_enable);
      wake(1'b0);
      tick(8);
      chk("deep", 0, core_clk_enable);
      wake(1'b1);
      count_to(3, n);
      count_to(0, n);
      chk("deepexit", 1, n >= HOLD);
      enter(pmrs_pkg::PMRS_REQ_IDLE);
      chk("idle", 2'h1, {core_clk_enable, periph_clk_enable});
      any_irq = 1'b1;
      tick(1);
      any_irq = 1'b0;
      tick(3);
      chk("idlewake", 1, core_clk_enable);
   endtask
   task brownout_and_levels;
      logic [5:0] exp [4];
      exp = '{6'h3f, 6'h17, 6'h13, 6'h01};
      brownout_warn = 1'b1;
      tick(2);
      chk("bod", 3'h6, {bod_irq, bod_status, chip_reset});
      brownout_warn = 1'b0;
      tick(2);
      chk("bodoff", 0, {bod_irq, bod_status});
      for (int i = 0; i < 4; i++) begin
         protect_level = 2'(i);
         tick(1);
         chk("access", exp[i], access);
      end
   endtask
   initial begin
      {rst, osc_running, flash_init_done, brownout_warn, wait_for_irq} = 5'h18;
      {clockless_irq, any_irq, rtc_alarm, clk_src_main_osc} = 4'h0;
      {rst_src, protect_level, n_errors, tests_run} = '0;
      power_req = pmrs_pkg::PMRS_REQ_IDLE;
      tick(2);
      rst = 1'b0;
      reset_and_hold();
      sources();
      sleep_wake(1'b0, `PMRS_IRC_WAKE_CYC * RC_DIV);
      sleep_wake(1'b1, 8);
      pdown_wake();
      deep_and_idle();
      brownout_and_levels();
      print_verdict();
   end
endmodule // pmrs_sequencer_bench
